// [logic/clock_chip_pkg.sv]
package clock_chip_pkg;

   // register numbers on the serial register port
   localparam logic [7:0] FUSE_PAGE_POINTER_ADDR         = 8'h22;
   localparam logic [7:0] IO_RAIL_SELECT_ADDR            = 8'h23;
   localparam logic [7:0] INPUT_FIXED_OUTPUT_ENABLE_ADDR = 8'h24;
   localparam logic [7:0] FLEXIBLE_OUTPUT_ENABLE_ADDR    = 8'h25;
   localparam logic [7:0] OUTPUT_DISABLE_CONTROL_ADDR    = 8'h26;
   localparam logic [7:0] INPUT_EVENT_IRQ_MASK_ADDR      = 8'h27;
   localparam logic [7:0] LOOP_EVENT_IRQ_MASK_ADDR       = 8'h28;

   localparam logic [7:0] REG_RESET_VALUE = 8'h00;
   // reserved bits of these registers read back as zero
   localparam logic [7:0] OUTPUT_DISABLE_WMASK = 8'hcf;
   localparam logic [7:0] LOOP_MASK_WMASK      = 8'hf0;

   // field positions
   localparam int RAIL_VDDIN_BIT    = 7;
   localparam int FREE_RUN_EN_BIT   = 5;
   localparam int INPUT_EN_LSB      = 4;
   localparam int BOTTOM_EN_LSB     = 2;
   localparam int TOP_EN_LSB        = 0;
   localparam int FREE_RUN_SEL_LSB  = 6;
   localparam int STAGGER_SEL_LSB   = 2;
   localparam int LOCK_LOSS_DIS_BIT = 1;
   localparam int REF_LOSS_DIS_BIT  = 0;
   localparam int DRIFT_MASK_LSB    = 4;
   localparam int LOSS_MASK_LSB     = 0;
   localparam int LOOP_MASK_LSB     = 4;

   // staggered loop-enable delays
   localparam int          CLK_FREQ_MHZ       = 25;
   localparam int unsigned STAGGER_TIME_US_0  = 4000;
   localparam int unsigned STAGGER_TIME_US_1  = 40000;
   localparam int unsigned STAGGER_TIME_US_2  = 400000;
   localparam int unsigned STAGGER_TIME_US_3  = 4000000;
   localparam int unsigned STAGGER_CYCLES_0   = STAGGER_TIME_US_0 * CLK_FREQ_MHZ;
   localparam int unsigned STAGGER_CYCLES_1   = STAGGER_TIME_US_1 * CLK_FREQ_MHZ;
   localparam int unsigned STAGGER_CYCLES_2   = STAGGER_TIME_US_2 * CLK_FREQ_MHZ;
   localparam int unsigned STAGGER_CYCLES_3   = STAGGER_TIME_US_3 * CLK_FREQ_MHZ;
   localparam int          STAGGER_CNT_W      = 27;

   // loop vectors: bit 0 is loop A, bit 3 is loop D
   typedef struct packed {
      logic [3:0] drift;
      logic [3:0] input_loss;
      logic [3:0] lock_loss;
      logic       ref_osc_loss;
   } clock_events_t;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   typedef enum logic [1:0] {
      SEQ_IDLE    = 2'b00,
      SEQ_STAGGER = 2'b01,
      SEQ_RUN     = 2'b10
   } seq_state_t;

endpackage

// [logic/loop_stagger_timer.sv]
`timescale 1ns/10ps
`default_nettype none
module loop_stagger_timer #(
   parameter int CNT_W = 27
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   // control
   input  wire logic             start,
   input  wire logic [CNT_W-1:0] load_value,
   // status
   output logic                  expired
);
   logic [CNT_W-1:0] count_reg;
   logic [CNT_W-1:0] count_next;
   logic             run_reg;
   logic             run_next;
   logic             expired_next;

   always_comb begin
      count_next   = count_reg;
      run_next     = run_reg;
      expired_next = 1'b0;
      if (start) begin
         count_next = load_value - CNT_W'(1);
         run_next   = 1'b1;
      end else if (run_reg) begin
         if (count_reg == '0) begin
            run_next     = 1'b0;
            expired_next = 1'b1;
         end else begin
            count_next = count_reg - CNT_W'(1);
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         count_reg <= '0;
         run_reg   <= 1'b0;
         expired   <= 1'b0;
      end else begin
         count_reg <= count_next;
         run_reg   <= run_next;
         expired   <= expired_next;
      end
   end
endmodule
`default_nettype wire

// [logic/clock_chip_enable_mask_regs.sv]
`timescale 1ns/10ps
`default_nettype none
module clock_chip_enable_mask_regs #(
   parameter int unsigned STAGGER_CYCLES_0 = clock_chip_pkg::STAGGER_CYCLES_0,
   parameter int unsigned STAGGER_CYCLES_1 = clock_chip_pkg::STAGGER_CYCLES_1,
   parameter int unsigned STAGGER_CYCLES_2 = clock_chip_pkg::STAGGER_CYCLES_2,
   parameter int unsigned STAGGER_CYCLES_3 = clock_chip_pkg::STAGGER_CYCLES_3
) (
   // clock and reset
   input  wire logic                    clk,
   input  wire logic                    rst_n,
   // register port
   input  wire clock_chip_pkg::reg_req_t reg_req,
   output logic [7:0]                   reg_rdata,
   output logic                         reg_rvalid,
   // monitored events and wake-up
   input  wire clock_chip_pkg::clock_events_t events,
   input  wire logic                    wake_start,
   input  wire logic                    fuse_locked,
   // configuration outputs
   output logic [7:0]                   fuse_page_sel,
   output logic                         vddio_from_vddin,
   output logic [3:0]                   input_enable_n,
   output logic [1:0]                   bottom_output_enable_n,
   output logic [1:0]                   top_output_enable_n,
   output logic [7:0]                   flex_output_enable_n,
   // loop control
   output logic [3:0]                   loop_output_disable,
   output logic [3:0]                   free_run_loop,
   output logic [3:0]                   loop_enable,
   // interrupt indication
   output logic                         irq
);
   localparam int W = clock_chip_pkg::STAGGER_CNT_W;

   if (STAGGER_CYCLES_0 == 0 || STAGGER_CYCLES_1 == 0 || STAGGER_CYCLES_2 == 0 ||
       STAGGER_CYCLES_3 == 0 || STAGGER_CYCLES_3 >= (64'd1 << W) ||
       STAGGER_CYCLES_2 >= (64'd1 << W) || STAGGER_CYCLES_1 >= (64'd1 << W) ||
       STAGGER_CYCLES_0 >= (64'd1 << W)) begin : g_bad_stagger
      $error("stagger cycle counts must lie between 1 and the timer range");
   end

   logic [7:0] fuse_reg, fuse_next;
   logic [7:0] rail_reg, rail_next;
   logic [7:0] io_en_reg, io_en_next;
   logic [7:0] flex_reg, flex_next;
   logic [7:0] oed_reg, oed_next;
   logic [7:0] imask_reg, imask_next;
   logic [7:0] lmask_reg, lmask_next;
   logic [7:0] rdata_next;

   // register writes and reads
   always_comb begin
      fuse_next  = fuse_reg;
      rail_next  = rail_reg;
      io_en_next = io_en_reg;
      flex_next  = flex_reg;
      oed_next   = oed_reg;
      imask_next = imask_reg;
      lmask_next = lmask_reg;
      if (reg_req.wr) begin
         case (reg_req.addr)
            clock_chip_pkg::FUSE_PAGE_POINTER_ADDR:         fuse_next = reg_req.wdata;
            clock_chip_pkg::IO_RAIL_SELECT_ADDR:            rail_next = reg_req.wdata;
            clock_chip_pkg::INPUT_FIXED_OUTPUT_ENABLE_ADDR: io_en_next = reg_req.wdata;
            clock_chip_pkg::FLEXIBLE_OUTPUT_ENABLE_ADDR:    flex_next = reg_req.wdata;
            clock_chip_pkg::OUTPUT_DISABLE_CONTROL_ADDR:
               oed_next = reg_req.wdata & clock_chip_pkg::OUTPUT_DISABLE_WMASK;
            clock_chip_pkg::INPUT_EVENT_IRQ_MASK_ADDR:      imask_next = reg_req.wdata;
            clock_chip_pkg::LOOP_EVENT_IRQ_MASK_ADDR:
               lmask_next = reg_req.wdata & clock_chip_pkg::LOOP_MASK_WMASK;
            default: ; // unmapped writes are dropped
         endcase
      end
      case (reg_req.addr)
         clock_chip_pkg::FUSE_PAGE_POINTER_ADDR:         rdata_next = fuse_reg;
         clock_chip_pkg::IO_RAIL_SELECT_ADDR:            rdata_next = rail_reg;
         clock_chip_pkg::INPUT_FIXED_OUTPUT_ENABLE_ADDR: rdata_next = io_en_reg;
         clock_chip_pkg::FLEXIBLE_OUTPUT_ENABLE_ADDR:    rdata_next = flex_reg;
         clock_chip_pkg::OUTPUT_DISABLE_CONTROL_ADDR:    rdata_next = oed_reg;
         clock_chip_pkg::INPUT_EVENT_IRQ_MASK_ADDR:      rdata_next = imask_reg;
         clock_chip_pkg::LOOP_EVENT_IRQ_MASK_ADDR:       rdata_next = lmask_reg;
         default:                                        rdata_next = 8'h00;
      endcase
      if (!reg_req.rd) begin
         rdata_next = reg_rdata;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         fuse_reg   <= clock_chip_pkg::REG_RESET_VALUE;
         rail_reg   <= clock_chip_pkg::REG_RESET_VALUE;
         io_en_reg  <= clock_chip_pkg::REG_RESET_VALUE;
         flex_reg   <= clock_chip_pkg::REG_RESET_VALUE;
         oed_reg    <= clock_chip_pkg::REG_RESET_VALUE;
         imask_reg  <= clock_chip_pkg::REG_RESET_VALUE;
         lmask_reg  <= clock_chip_pkg::REG_RESET_VALUE;
         reg_rdata  <= 8'h00;
         reg_rvalid <= 1'b0;
      end else begin
         fuse_reg   <= fuse_next;
         rail_reg   <= rail_next;
         io_en_reg  <= io_en_next;
         flex_reg   <= flex_next;
         oed_reg    <= oed_next;
         imask_reg  <= imask_next;
         lmask_reg  <= lmask_next;
         reg_rdata  <= rdata_next;
         reg_rvalid <= reg_req.rd;
      end
   end

   // register fields straight onto the configuration outputs
   assign fuse_page_sel          = fuse_reg;
   assign vddio_from_vddin       = rail_reg[clock_chip_pkg::RAIL_VDDIN_BIT];
   assign input_enable_n         = io_en_reg[clock_chip_pkg::INPUT_EN_LSB +: 4];
   assign bottom_output_enable_n = io_en_reg[clock_chip_pkg::BOTTOM_EN_LSB +: 2];
   assign top_output_enable_n    = io_en_reg[clock_chip_pkg::TOP_EN_LSB +: 2];
   assign flex_output_enable_n   = flex_reg;

   // output disable and interrupt
   logic [3:0] loop_mask;
   logic [3:0] oed_next_v;
   logic       irq_next;

   always_comb begin
      // mask register lists loops A..D from bit 7 downward
      loop_mask = {lmask_reg[clock_chip_pkg::LOOP_MASK_LSB],
                   lmask_reg[clock_chip_pkg::LOOP_MASK_LSB + 1],
                   lmask_reg[clock_chip_pkg::LOOP_MASK_LSB + 2],
                   lmask_reg[clock_chip_pkg::LOOP_MASK_LSB + 3]};
      oed_next_v = (events.lock_loss & {4{oed_reg[clock_chip_pkg::LOCK_LOSS_DIS_BIT]}})
                 | {4{events.ref_osc_loss & oed_reg[clock_chip_pkg::REF_LOSS_DIS_BIT]}};
      irq_next = |(events.drift & ~imask_reg[clock_chip_pkg::DRIFT_MASK_LSB +: 4])
               | |(events.input_loss & ~imask_reg[clock_chip_pkg::LOSS_MASK_LSB +: 4])
               | |(events.lock_loss & ~loop_mask);
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         loop_output_disable <= 4'h0;
         irq                 <= 1'b0;
      end else begin
         loop_output_disable <= oed_next_v;
         irq                 <= irq_next;
      end
   end

   // wake-up: free-run selection and staggered loop enables
   clock_chip_pkg::seq_state_t state_reg, state_next;
   logic [3:0]   free_next;
   logic [3:0]   loop_en_next;
   logic         timer_start;
   logic         timer_expired;
   logic [W-1:0] stagger_load;

   always_comb begin
      case (oed_reg[clock_chip_pkg::STAGGER_SEL_LSB +: 2])
         2'b00:   stagger_load = W'(STAGGER_CYCLES_0);
         2'b01:   stagger_load = W'(STAGGER_CYCLES_1);
         2'b10:   stagger_load = W'(STAGGER_CYCLES_2);
         default: stagger_load = W'(STAGGER_CYCLES_3);
      endcase
      state_next   = state_reg;
      free_next    = free_run_loop;
      loop_en_next = loop_enable;
      timer_start  = 1'b0;
      if (wake_start) begin
         free_next = 4'h0;
         if (rail_reg[clock_chip_pkg::FREE_RUN_EN_BIT]) begin
            free_next[oed_reg[clock_chip_pkg::FREE_RUN_SEL_LSB +: 2]] = 1'b1;
         end
         if (fuse_locked) begin
            loop_en_next = 4'h1;
            timer_start  = 1'b1;
            state_next   = clock_chip_pkg::SEQ_STAGGER;
         end else begin
            loop_en_next = 4'hf;
            state_next   = clock_chip_pkg::SEQ_RUN;
         end
      end else begin
         case (state_reg)
            clock_chip_pkg::SEQ_STAGGER: begin
               if (timer_expired) begin
                  loop_en_next = 4'hf;
                  state_next   = clock_chip_pkg::SEQ_RUN;
               end
            end
            clock_chip_pkg::SEQ_IDLE: ;
            clock_chip_pkg::SEQ_RUN:  ;
            default: state_next = clock_chip_pkg::SEQ_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_reg     <= clock_chip_pkg::SEQ_IDLE;
         free_run_loop <= 4'h0;
         loop_enable   <= 4'h0;
      end else begin
         state_reg     <= state_next;
         free_run_loop <= free_next;
         loop_enable   <= loop_en_next;
      end
   end

   loop_stagger_timer #(
      .CNT_W (W)
   ) u_stagger (
      .clk        (clk),
      .rst_n      (rst_n),
      .start      (timer_start),
      .load_value (stagger_load),
      .expired    (timer_expired)
   );

   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   function automatic logic is_wr(input logic [7:0] a);
      return reg_req.wr && reg_req.addr == a;
   endfunction

   property p_reset_zero;
      $rose(rst_n) |-> fuse_page_sel == 8'h00 && input_enable_n == 4'h0
         && flex_output_enable_n == 8'h00 && !irq;
   endproperty
   a_reset_zero: assert property (p_reset_zero) else $error("config not zero after reset");

   property p_fuse;
      is_wr(clock_chip_pkg::FUSE_PAGE_POINTER_ADDR) |=> fuse_page_sel == $past(reg_req.wdata);
   endproperty
   a_fuse: assert property (p_fuse) else $error("fuse pointer not written");

   property p_input_en;
      is_wr(clock_chip_pkg::INPUT_FIXED_OUTPUT_ENABLE_ADDR)
         |=> input_enable_n == $past(reg_req.wdata[7:4]);
   endproperty
   a_input_en: assert property (p_input_en) else $error("input enables wrong");

   property p_fixed_en;
      is_wr(clock_chip_pkg::INPUT_FIXED_OUTPUT_ENABLE_ADDR)
         |=> bottom_output_enable_n == $past(reg_req.wdata[3:2])
             && top_output_enable_n == $past(reg_req.wdata[1:0]);
   endproperty
   a_fixed_en: assert property (p_fixed_en) else $error("fixed output enables wrong");

   property p_flex_en;
      is_wr(clock_chip_pkg::FLEXIBLE_OUTPUT_ENABLE_ADDR)
         |=> flex_output_enable_n == $past(reg_req.wdata);
   endproperty
   a_flex_en: assert property (p_flex_en) else $error("flex output enables wrong");

   property p_free_run;
      wake_start && rail_reg[5] && oed_reg[7:6] == 2'b10 |=> free_run_loop == 4'b0100;
   endproperty
   a_free_run: assert property (p_free_run) else $error("free-run loop wrong");

   property p_stagger;
      wake_start && fuse_locked |=> loop_enable == 4'h1 ##1 (loop_enable == 4'h1)[*2];
   endproperty
   a_stagger: assert property (p_stagger) else $error("loops enabled before delay");

   property p_lock_loss;
      oed_reg[1] && events.lock_loss[2] |=> loop_output_disable[2];
   endproperty
   a_lock_loss: assert property (p_lock_loss) else $error("lock loss did not disable");

   property p_ref_loss;
      oed_reg[0] && events.ref_osc_loss |=> loop_output_disable == 4'hf;
   endproperty
   a_ref_loss: assert property (p_ref_loss) else $error("oscillator loss did not disable");

   property p_drift_mask;
      events.drift[3] && !imask_reg[7] |=> irq;
   endproperty
   a_drift_mask: assert property (p_drift_mask) else $error("drift interrupt missing");

   property p_loss_mask;
      events.input_loss[0] && !imask_reg[0] |=> irq;
   endproperty
   a_loss_mask: assert property (p_loss_mask) else $error("clock loss interrupt missing");

   property p_loop_mask;
      events.lock_loss[0] && !lmask_reg[7] |=> irq;
   endproperty
   a_loop_mask: assert property (p_loop_mask) else $error("lock loss interrupt missing");

   property p_all_masked;
      imask_reg == 8'hff && lmask_reg == 8'hf0 && $stable(imask_reg) |=> !irq;
   endproperty
   a_all_masked: assert property (p_all_masked) else $error("masked event raised interrupt");

   c_stagger_done: cover property (state_reg == clock_chip_pkg::SEQ_STAGGER ##1 loop_enable == 4'hf);
   c_irq:          cover property ($rose(irq));
   c_ref_disable:  cover property (loop_output_disable == 4'hf);
endmodule
`default_nettype wire

// [verification/reg_host_model.sv]
`timescale 1ns/10ps
`default_nettype none
module reg_host_model (
   // clock
   input  wire logic                clk,
   // register port
   output clock_chip_pkg::reg_req_t reg_req,
   input  wire logic [7:0]          reg_rdata,
   input  wire logic                reg_rvalid
);
   // an idle port shows the inverse of the last address so a stale value never decodes
   initial begin
      reg_req = '0;
      reg_req.addr = 8'hff;
   end

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      #1;
      reg_req.wr = 1'b1;
      reg_req.addr = a;
      reg_req.wdata = d;
      @(posedge clk);
      #1;
      reg_req.wr = 1'b0;
      reg_req.addr = ~a;
      reg_req.wdata = ~d;
   endtask

   // ok stays low if the answer never shows within a few cycles
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d, output bit ok);
      int i;
      @(posedge clk);
      #1;
      reg_req.rd = 1'b1;
      reg_req.addr = a;
      @(posedge clk);
      #1;
      reg_req.rd = 1'b0;
      reg_req.addr = ~a;
      ok = 1'b0;
      d = 8'h00;
      for (i = 0; i < 4 && !ok; i++) begin
         if (reg_rvalid === 1'b1) begin
            ok = 1'b1;
            d = reg_rdata;
         end else begin
            @(posedge clk);
            #1;
         end
      end
   endtask
endmodule
`default_nettype wire

// [verification/testbench.sv]
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) \
   begin \
      tests_run++; \
      if ((got) !== (exp)) begin \
         n_errors++; \
         $display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); \
      end \
   end
module testbench;
   logic                          clk;
   logic                          rst_n;
   logic                          wake_start;
   logic                          fuse_locked;
   clock_chip_pkg::reg_req_t      reg_req;
   clock_chip_pkg::clock_events_t events;
   logic [7:0]                    reg_rdata;
   logic                          reg_rvalid;
   logic [7:0]                    fuse_page_sel;
   logic                          vddio_from_vddin;
   logic [3:0]                    input_enable_n;
   logic [1:0]                    bottom_output_enable_n;
   logic [1:0]                    top_output_enable_n;
   logic [7:0]                    flex_output_enable_n;
   logic [3:0]                    loop_output_disable;
   logic [3:0]                    free_run_loop;
   logic [3:0]                    loop_enable;
   logic                          irq;
   logic [7:0]                    shadow [8'h22:8'h28];
   int                            n_errors;
   int                            tests_run;
   integer                        seed;
   // short stagger counts keep the wake-up runs brief
   int unsigned                   stg [4] = '{4, 6, 8, 10};

   clock_chip_enable_mask_regs #(
      .STAGGER_CYCLES_0(4), .STAGGER_CYCLES_1(6), .STAGGER_CYCLES_2(8), .STAGGER_CYCLES_3(10)
   ) DUT (
      .clk(clk), .rst_n(rst_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .events(events), .wake_start(wake_start),
      .fuse_locked(fuse_locked), .fuse_page_sel(fuse_page_sel),
      .vddio_from_vddin(vddio_from_vddin), .input_enable_n(input_enable_n),
      .bottom_output_enable_n(bottom_output_enable_n),
      .top_output_enable_n(top_output_enable_n), .flex_output_enable_n(flex_output_enable_n),
      .loop_output_disable(loop_output_disable), .free_run_loop(free_run_loop),
      .loop_enable(loop_enable), .irq(irq)
   );

   reg_host_model host (
      .clk(clk), .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid)
   );

   always #20 clk = ~clk;

   function automatic logic [7:0] wmask(input logic [7:0] a);
      if (a == 8'h26) return clock_chip_pkg::OUTPUT_DISABLE_WMASK;
      if (a == 8'h28) return clock_chip_pkg::LOOP_MASK_WMASK;
      return 8'hff;
   endfunction

   function automatic logic irq_exp(input clock_chip_pkg::clock_events_t e,
                                    input logic [7:0] m1, input logic [7:0] m2);
      logic [3:0] lm;
      lm = {m2[4], m2[5], m2[6], m2[7]};
      return (|(e.drift & ~m1[7:4])) || (|(e.input_loss & ~m1[3:0])) || (|(e.lock_loss & ~lm));
   endfunction

   function automatic logic [3:0] lod_exp(input clock_chip_pkg::clock_events_t e,
                                          input logic [7:0] c);
      return (c[1] ? e.lock_loss : 4'h0) | ((c[0] && e.ref_osc_loss) ? 4'hf : 4'h0);
   endfunction

   task automatic test_done();
      $display("errors %0d of %0d checks", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      host.wr_reg(a, d);
      if (a >= 8'h22 && a <= 8'h28) shadow[a] = d & wmask(a);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      bit         ok;
      host.rd_reg(a, d, ok);
      if (!ok) begin
         n_errors++;
         test_done();
      end
      `CHK(d, e)
   endtask

   task automatic check_cfg();
      `CHK(fuse_page_sel, shadow[8'h22])
      `CHK(vddio_from_vddin, shadow[8'h23][7])
      `CHK(input_enable_n, shadow[8'h24][7:4])
      `CHK(bottom_output_enable_n, shadow[8'h24][3:2])
      `CHK(top_output_enable_n, shadow[8'h24][1:0])
      `CHK(flex_output_enable_n, shadow[8'h25])
   endtask

   task automatic wake(input bit locked, input int unsigned n, input logic [3:0] fr);
      fuse_locked = locked;
      wake_start = 1'b1;
      @(posedge clk);
      #1;
      wake_start = 1'b0;
      @(posedge clk);
      #1;
      `CHK(free_run_loop, fr)
      `CHK(loop_enable, locked ? 4'h1 : 4'hf)
      if (locked) begin
         // the others come up on the edge after the timer runs out
         repeat (n - 1) @(posedge clk);
         #1;
         `CHK(loop_enable, 4'h1)
         @(posedge clk);
         #1;
         `CHK(loop_enable, 4'hf)
      end
   endtask

   initial begin
      repeat (100000) @(posedge clk);
      n_errors++;
      test_done();
   end

   initial begin
      logic [7:0] a;
      logic [7:0] v;
      int         k;
      clk = 1'b0;
      rst_n = 1'b0;
      wake_start = 1'b0;
      fuse_locked = 1'b0;
      events = '0;
      seed = 32'h05ea;
      n_errors = 0;
      tests_run = 0;
      for (k = 8'h22; k <= 8'h28; k++) shadow[k] = 8'h00;
      repeat (2) @(posedge clk);
      #1;
      rst_n = 1'b1;
      @(posedge clk);
      #1;
      check_cfg();
      `CHK({loop_enable, free_run_loop, loop_output_disable, irq}, 13'h0)
      for (k = 8'h22; k <= 8'h28; k++) rd_chk(k[7:0], 8'h00);
      // every register: all ones, then random values, read back; the fuse, rail and enable registers also checked at the pins
      for (k = 0; k < 28; k++) begin
         a = 8'h22 + 8'(k % 7);
         v = (k < 7) ? 8'hff : 8'($random(seed));
         wr(a, v);
         check_cfg();
         rd_chk(a, v & wmask(a));
      end
      wr(8'h30, 8'h5a);
      check_cfg();
      rd_chk(8'h30, 8'h00);
      rd_chk(8'h21, 8'h00);
      // event sources against masks; the first block masks everything
      for (k = 0; k < 200; k++) begin
         if (k % 20 == 0) begin
            wr(8'h27, (k == 0) ? 8'hff : 8'($random(seed)));
            wr(8'h28, (k == 0) ? 8'hf0 : 8'($random(seed)));
            wr(8'h26, 8'($random(seed)));
         end
         events = 13'($random(seed));
         if (k < 20) events = 13'h1ffe;
         @(posedge clk);
         #1;
         `CHK(irq, irq_exp(events, shadow[8'h27], shadow[8'h28]))
         `CHK(loop_output_disable, lod_exp(events, shadow[8'h26]))
      end
      events = 13'h0001;
      wr(8'h26, 8'h01);
      // the disable follows the new control value one edge after the write lands
      @(posedge clk);
      #1;
      `CHK(loop_output_disable, 4'hf)
      events = '0;
      // each stagger code, each free-run choice, then an unlocked wake with free-run off
      for (k = 0; k < 4; k++) begin
         wr(8'h23, 8'h20);
         wr(8'h26, {2'(3 - k), 2'b00, 2'(k), 2'b00});
         wake(1'b1, stg[k], 4'(1 << (3 - k)));
      end
      wr(8'h23, 8'h00);
      wake(1'b0, 0, 4'h0);
      // reset in mid-run must clear everything written above
      wr(8'h25, 8'h3c);
      rst_n = 1'b0;
      @(posedge clk);
      #1;
      rst_n = 1'b1;
      for (k = 8'h22; k <= 8'h28; k++) shadow[k] = 8'h00;
      @(posedge clk);
      #1;
      check_cfg();
      `CHK({loop_enable, free_run_loop, loop_output_disable, irq}, 13'h0)
      test_done();
   end
endmodule
`default_nettype wire
